// ===== src/sfs_front_end.sv
// Serial flash front end: pin protocol, pause, status write gating, buffers.
//
// How it works
// R1 - Input bits taken on rising serial clock.
// R2 - Output bits change only after falling edges.
// R3 - Mode 0 and mode 3 both work alike.
// R4 - Chip select falling selects; high means standby.
// R5 - Master keeps chip select low whole command.
// R6 - Dual mode uses both pins both directions.
// R7 - 128 sectors of 4K, 8 blocks of 64K.
// R8 - Pause keeps bit position of current transfer.
// R9 - Master pauses only while chip select low.
// R10 - Pause enters and leaves on hold with clock low.
// R11 - Master never moves hold while clock high.
// R12 - Paused: output released, clock and input ignored.
// R13 - Chip select high while paused aborts to standby.
// R14 - Pause lasts while hold low; resume raises it.
// R15 - Status write refused when protect low, locked.
// R16 - Lock bit is status bit 7, protect low only.
// R17 - Protection bits guard array and status register.
// R18 - Bytes MSB first; partial byte aborted by deselect.
// R19 - Standby: output released, bus activity ignored.
`timescale 1ns/1ps

module sfs_front_end (
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire logic                          sclk,
	input  wire logic                          csN,
	input  wire logic                          holdN,
	input  wire logic                          wpN,
	input  wire logic [sfs_pkg::IO_W-1:0]      dualIoIn,
	output logic      [sfs_pkg::IO_W-1:0]      dualIoOut,
	output logic      [sfs_pkg::IO_W-1:0]      dualIoOe,
	input  wire logic                          dualMode,
	input  wire logic [sfs_pkg::BYTE_W-1:0]    txData,
	input  wire logic                          txValid,
	output logic                               txReady,
	output logic      [sfs_pkg::BYTE_W-1:0]    rxData,
	output logic                               rxFirst,
	output logic                               rxValid,
	input  wire logic                          rxReady,
	output logic                               rxOverrun,
	output logic      [sfs_pkg::BYTE_W-1:0]    statusReg,
	output logic                               statusWritten,
	output logic                               statusRejected,
	output logic                               selected,
	output logic                               paused,
	input  wire logic [sfs_pkg::ADDR_W-1:0]    protAddr,
	output logic                               protHit,
	output logic      [sfs_pkg::SECTOR_W-1:0]  sectorIdx,
	output logic      [sfs_pkg::BLOCK_W-1:0]   blockIdx
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	sfs_pkg::sfs_regs_t r_q;
	sfs_pkg::sfs_regs_t r_d;

	logic                          sclkNow;
	logic                          sclkRise;
	logic                          sclkFall;
	logic                          csRise;
	logic                          csFall;
	logic                          holdRise;
	logic                          holdFall;
	logic                          locked;
	logic [sfs_pkg::CNT_W:0]       step;
	logic [sfs_pkg::CNT_W:0]       cntSum;
	logic                          byteDone;
	logic [sfs_pkg::BYTE_W-1:0]    rxNext;
	logic [sfs_pkg::BYTE_W-1:0]    txNext;
	logic                          push;
	logic                          pop;
	sfs_pkg::sfs_rx_slot_t         newWord;
	logic [sfs_pkg::BLOCK_W:0]     protBlocks;
	logic [sfs_pkg::BLOCK_W:0]     queryBlock;
	logic [2:0]                    protLevel;

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		r_d = r_q;

		// Pins come from the master's domain; only the second stage and its delayed copy are looked at.
		r_d.sync1 = {wpN, holdN, csN, sclk, dualIoIn};
		r_d.sync2 = r_q.sync1;
		r_d.prev  = r_q.sync2;

		sclkNow  = r_q.sync2[sfs_pkg::SY_SCLK];
		sclkRise = sclkNow & ~r_q.prev[sfs_pkg::SY_SCLK];
		sclkFall = ~sclkNow & r_q.prev[sfs_pkg::SY_SCLK];
		csRise   = r_q.sync2[sfs_pkg::SY_CSN] & ~r_q.prev[sfs_pkg::SY_CSN];
		csFall   = ~r_q.sync2[sfs_pkg::SY_CSN] & r_q.prev[sfs_pkg::SY_CSN];
		holdRise = r_q.sync2[sfs_pkg::SY_HOLDN] & ~r_q.prev[sfs_pkg::SY_HOLDN];
		holdFall = ~r_q.sync2[sfs_pkg::SY_HOLDN] & r_q.prev[sfs_pkg::SY_HOLDN];

		// The lock bit only counts while the protect pin is low.
		locked = ~r_q.sync2[sfs_pkg::SY_WPN] & r_q.status[sfs_pkg::LOCK_BIT]; // [R16]

		step   = dualMode ? sfs_pkg::STEP_DUAL : sfs_pkg::STEP_SINGLE; // [R6]
		cntSum = {1'b0, r_q.bitCnt} + step;

		// Most significant bit first; in dual mode the upper pin carries the higher bit.
		rxNext = dualMode ?
			{r_q.rxShift[sfs_pkg::BYTE_W-3:0], r_q.sync2[sfs_pkg::SY_IO1],
				r_q.sync2[sfs_pkg::SY_IO0]} :
			{r_q.rxShift[sfs_pkg::BYTE_W-2:0], r_q.sync2[sfs_pkg::SY_IO0]}; // [R18] [R6]
		txNext = dualMode ?
			{r_q.txShift[sfs_pkg::BYTE_W-3:0], 2'h0} :
			{r_q.txShift[sfs_pkg::BYTE_W-2:0], 1'h0};

		byteDone = 1'b0;
		push     = 1'b0;
		newWord  = '0;

		r_d.statusWritten  = 1'b0;
		r_d.statusRejected = 1'b0;

		unique case (r_q.state)
			sfs_pkg::ST_STANDBY: begin
				// Clock and data are ignored until chip select falls.
				r_d.bitCnt  = '0; // [R19]
				r_d.byteCnt = sfs_pkg::BYTES_NONE;
				r_d.txOn    = 1'b0;
				if (csFall) begin
					r_d.state   = sfs_pkg::ST_SELECTED; // [R4]
					r_d.overrun = 1'b0;
				end
			end
			sfs_pkg::ST_SELECTED: begin
				if (csRise) begin
					// A byte cut short is simply dropped.
					r_d.state  = sfs_pkg::ST_STANDBY; // [R4] [R18]
					r_d.bitCnt = '0;
					r_d.txOn   = 1'b0;
				end else if (holdFall && !sclkNow) begin
					r_d.state = sfs_pkg::ST_PAUSED; // [R10]
				end else if (sclkRise) begin
					// Sampling edge is the rising one whatever the idle level.
					r_d.rxShift = rxNext; // [R1] [R3]
					r_d.bitCnt  = cntSum[sfs_pkg::CNT_W-1:0];
					byteDone    = cntSum[sfs_pkg::CNT_W]; // [R18]
				end else if (sclkFall) begin
					// A fall before any rise, as in mode 3, finds no byte done.
					if (r_q.bitCnt == '0 && r_q.byteCnt != sfs_pkg::BYTES_NONE) begin
						r_d.txOn = r_q.txHoldValid; // [R2] [R3]
						r_d.txShift = r_q.txHoldValid ? r_q.txHold : sfs_pkg::TX_IDLE;
						r_d.txHoldValid = 1'b0;
					end else if (r_q.txOn) begin
						r_d.txShift = txNext; // [R2]
					end
				end
			end
			sfs_pkg::ST_PAUSED: begin
				// Counters and shifters stand still, so the transfer resumes in place.
				if (csRise) begin
					r_d.state  = sfs_pkg::ST_STANDBY; // [R13]
					r_d.bitCnt = '0;
					r_d.txOn   = 1'b0;
				end else if (holdRise && !sclkNow) begin
					r_d.state = sfs_pkg::ST_SELECTED; // [R10] [R14] [R8]
				end
			end
			default: begin
				r_d.state = sfs_pkg::ST_STANDBY;
			end
		endcase

		////////////////////////////////////////////////////////////////////////////
		// Command tracking and status write gating.

		if (byteDone) begin
			push          = 1'b1;
			newWord.valid = 1'b1;
			newWord.first = (r_q.byteCnt == sfs_pkg::BYTES_NONE);
			newWord.data  = rxNext;
			if (r_q.byteCnt == sfs_pkg::BYTES_NONE) begin
				r_d.opcode = rxNext;
			end
			if (r_q.byteCnt == sfs_pkg::BYTES_ONE &&
				r_q.opcode == sfs_pkg::STATUS_WRITE_OP) begin
				if (locked) begin
					r_d.statusRejected = 1'b1; // [R15] [R17]
				end else begin
					r_d.status = (r_q.status & ~sfs_pkg::STATUS_WR_MASK) |
						(rxNext & sfs_pkg::STATUS_WR_MASK); // [R15] [R17]
					r_d.statusWritten = 1'b1;
				end
			end
			if (r_q.byteCnt != sfs_pkg::BYTES_SAT) begin
				r_d.byteCnt = r_q.byteCnt + sfs_pkg::BYTES_ONE;
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// Transmit holding register: one word waits for the next byte boundary.

		if (txValid && !r_q.txHoldValid) begin
			r_d.txHoldValid = 1'b1;
			r_d.txHold      = txData;
		end

		////////////////////////////////////////////////////////////////////////////
		// Two-entry receive buffer. The bus master cannot be stalled, so a third
		// word with both slots full is dropped and reported instead.

		pop = r_q.slot0.valid & rxReady;
		if (pop) begin
			r_d.slot0       = r_q.slot1;
			r_d.slot1.valid = 1'b0;
		end
		if (push) begin
			if (!r_d.slot0.valid) begin
				r_d.slot0 = newWord;
			end else if (!r_d.slot1.valid) begin
				r_d.slot1 = newWord;
			end else begin
				r_d.overrun = 1'b1;
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// Pin drive. Released in standby and pause; the word position is kept.

		r_d.pinOut = {r_d.txShift[sfs_pkg::BYTE_W-1], r_d.txShift[sfs_pkg::BYTE_W-2]};
		if (r_d.state == sfs_pkg::ST_SELECTED && r_d.txOn) begin
			r_d.pinOe = dualMode ? 2'h3 : 2'h2; // [R6] [R2]
		end else begin
			r_d.pinOe = 2'h0; // [R12] [R19]
		end
		if (!dualMode) begin
			r_d.pinOut[sfs_pkg::SY_IO0] = 1'b0;
		end

		////////////////////////////////////////////////////////////////////////////
		// Protection query against the 64 KByte block map.

		protLevel = {r_q.status[sfs_pkg::BP2_BIT], r_q.status[sfs_pkg::BP1_BIT],
			r_q.status[sfs_pkg::BP0_BIT]};
		unique case (protLevel[1:0])
			2'h1:    protBlocks = sfs_pkg::BLOCKS_L1;
			2'h2:    protBlocks = sfs_pkg::BLOCKS_L2;
			2'h3:    protBlocks = sfs_pkg::BLOCKS_L3;
			default: protBlocks = '0;
		endcase
		if (protLevel[2]) begin
			protBlocks = sfs_pkg::BLOCKS_ALL;
		end
		queryBlock    = {1'b0, protAddr[sfs_pkg::ADDR_W-1:sfs_pkg::BLOCK_SHIFT]}; // [R7]
		r_d.blockIdx  = protAddr[sfs_pkg::ADDR_W-1:sfs_pkg::BLOCK_SHIFT]; // [R7]
		r_d.sectorIdx = protAddr[sfs_pkg::ADDR_W-1:sfs_pkg::SECTOR_SHIFT]; // [R7]
		if (r_q.status[sfs_pkg::TB_BIT]) begin
			r_d.protHit = queryBlock < protBlocks; // [R17]
		end else begin
			r_d.protHit = queryBlock >= (sfs_pkg::BLOCKS_ALL - protBlocks); // [R17]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge mclk) begin
		if (rst) begin
			r_q                <= '0;
			r_q.sync1          <= sfs_pkg::SYNC_IDLE;
			r_q.sync2          <= sfs_pkg::SYNC_IDLE;
			r_q.prev           <= sfs_pkg::SYNC_IDLE;
			r_q.state          <= sfs_pkg::ST_STANDBY;
			r_q.txShift        <= sfs_pkg::TX_IDLE;
			r_q.status         <= sfs_pkg::STATUS_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, each straight from the state register.

	assign dualIoOut      = r_q.pinOut;
	assign dualIoOe       = r_q.pinOe;
	assign txReady        = ~r_q.txHoldValid;
	assign rxData         = r_q.slot0.data;
	assign rxFirst        = r_q.slot0.first;
	assign rxValid        = r_q.slot0.valid;
	assign rxOverrun      = r_q.overrun;
	assign statusReg      = r_q.status;
	assign statusWritten  = r_q.statusWritten;
	assign statusRejected = r_q.statusRejected;
	assign selected       = r_q.state == sfs_pkg::ST_SELECTED;
	assign paused         = r_q.state == sfs_pkg::ST_PAUSED;
	assign protHit        = r_q.protHit;
	assign sectorIdx      = r_q.sectorIdx;
	assign blockIdx       = r_q.blockIdx;

endmodule

// ===== src/sfs_pkg.sv
// Constants and types shared by the serial flash front end.
package sfs_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths of the serial path.
	localparam int          BYTE_W      = 8;
	localparam int          IO_W        = 2;
	localparam int          CNT_W       = 3;
	localparam logic [CNT_W:0] STEP_SINGLE = 4'h1;
	localparam logic [CNT_W:0] STEP_DUAL   = 4'h2;
	localparam logic [1:0]  BYTES_NONE  = 2'h0;
	localparam logic [1:0]  BYTES_ONE   = 2'h1;
	localparam logic [1:0]  BYTES_SAT   = 2'h2;
	localparam logic [7:0]  TX_IDLE     = 8'hff;

	// Opcode of the status write command; not given alongside the pin rules.
	localparam logic [7:0]  STATUS_WRITE_OP = 8'h01;

	////////////////////////////////////////////////////////////////////////////////
	// Synchroniser lanes, and their levels while nothing drives the bus.
	localparam int          SYNC_W     = 6;
	localparam int          SY_IO0     = 0;
	localparam int          SY_IO1     = 1;
	localparam int          SY_SCLK    = 2;
	localparam int          SY_CSN     = 3;
	localparam int          SY_HOLDN   = 4;
	localparam int          SY_WPN     = 5;
	localparam logic [SYNC_W-1:0] SYNC_IDLE = 6'h38;

	////////////////////////////////////////////////////////////////////////////////
	// Status register fields.
	localparam int          LOCK_BIT   = 7;
	localparam int          TB_BIT     = 5;
	localparam int          BP2_BIT    = 4;
	localparam int          BP1_BIT    = 3;
	localparam int          BP0_BIT    = 2;
	localparam logic [7:0]  STATUS_WR_MASK = 8'hbc;
	localparam logic [7:0]  STATUS_RESET   = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Array organisation: 4 KByte sectors inside 64 KByte blocks.
	localparam int          ADDR_W       = 19;
	localparam int          SECTOR_SHIFT = 12;
	localparam int          BLOCK_SHIFT  = 16;
	localparam int          SECTOR_W     = 7;
	localparam int          BLOCK_W      = 3;
	localparam int          NUM_SECTORS  = 128;
	localparam int          NUM_BLOCKS   = 8;
	localparam logic [BLOCK_W:0] BLOCKS_ALL = 4'h8;
	localparam logic [BLOCK_W:0] BLOCKS_L1  = 4'h1;
	localparam logic [BLOCK_W:0] BLOCKS_L2  = 4'h2;
	localparam logic [BLOCK_W:0] BLOCKS_L3  = 4'h4;

	typedef enum logic [2:0] {
		ST_STANDBY  = 3'b001,
		ST_SELECTED = 3'b010,
		ST_PAUSED   = 3'b100
	} sfs_state_t;

	typedef struct packed {
		logic             valid;
		logic             first;
		logic [BYTE_W-1:0] data;
	} sfs_rx_slot_t;

	typedef struct packed {
		logic [SYNC_W-1:0]   sync1;
		logic [SYNC_W-1:0]   sync2;
		logic [SYNC_W-1:0]   prev;
		sfs_state_t          state;
		logic [CNT_W-1:0]    bitCnt;
		logic [1:0]          byteCnt;
		logic [BYTE_W-1:0]   rxShift;
		logic [BYTE_W-1:0]   opcode;
		logic [BYTE_W-1:0]   txShift;
		logic                txOn;
		logic                txHoldValid;
		logic [BYTE_W-1:0]   txHold;
		sfs_rx_slot_t        slot0;
		sfs_rx_slot_t        slot1;
		logic                overrun;
		logic [BYTE_W-1:0]   status;
		logic                statusWritten;
		logic                statusRejected;
		logic [IO_W-1:0]     pinOut;
		logic [IO_W-1:0]     pinOe;
		logic                protHit;
		logic [SECTOR_W-1:0] sectorIdx;
		logic [BLOCK_W-1:0]  blockIdx;
	} sfs_regs_t;

endpackage

// ===== verification/sfs_front_end_checker.sv
// Port-level assertions for the serial flash front end.
`timescale 1ns/1ps

module sfs_front_end_checker (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        sclk,
	input wire logic        csN,
	input wire logic        holdN,
	input wire logic        wpN,
	input wire logic [1:0]  dualIoOut,
	input wire logic [1:0]  dualIoOe,
	input wire logic [7:0]  statusReg,
	input wire logic        statusWritten,
	input wire logic        statusRejected,
	input wire logic        selected,
	input wire logic        paused,
	input wire logic [18:0] protAddr,
	input wire logic [6:0]  sectorIdx,
	input wire logic [2:0]  blockIdx
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////
	a_standby_released: assert property (!selected && !$past(selected) |-> dualIoOe == 2'h0)
		else $error("output enabled while deselected");
	a_pause_released: assert property (paused && $past(paused) |-> dualIoOe == 2'h0)
		else $error("output enabled while paused");
	// The output may only move three or four cycles after a falling serial clock.
	a_out_after_fall: assert property ($changed(dualIoOut) && dualIoOe != 2'h0
		&& $past(dualIoOe) != 2'h0 |-> ($past(sclk, 4) && !$past(sclk, 3))
		|| ($past(sclk, 5) && !$past(sclk, 4)))
		else $error("output changed without a falling clock");
	a_dual_enable: assert property (dualIoOe != 2'h1)
		else $error("bad output enable pattern");
	a_deselect_idle: assert property (csN [*6] |-> !selected && !paused)
		else $error("not in standby with select high");
	a_pause_entry: assert property ($rose(paused) |-> !$past(holdN, 3) && !$past(sclk, 3))
		else $error("pause entered without hold low and clock low");
	a_reject_locked: assert property (statusRejected |-> !wpN && statusReg[7]
		&& $stable(statusReg))
		else $error("status write refused wrongly");
	a_write_allowed: assert property (statusWritten |-> wpN || !$past(statusReg[7]))
		else $error("status written while locked");
	a_status_fields: assert property ($changed(statusReg) |-> (statusReg & 8'h43) == 8'h00
		&& (statusWritten || $past(statusWritten)))
		else $error("status changed outside a write");
	a_prot_index: assert property (1'b1 |=> sectorIdx == $past(protAddr[18:12])
		&& blockIdx == $past(protAddr[18:16]))
		else $error("sector or block index wrong");

	c_written: cover property (statusWritten);
	c_rejected: cover property (statusRejected);
	c_paused: cover property ($rose(paused));
endmodule

bind sfs_front_end sfs_front_end_checker i_chk (.mclk(mclk), .rst(rst), .sclk(sclk), .csN(csN),
	.holdN(holdN), .wpN(wpN), .dualIoOut(dualIoOut), .dualIoOe(dualIoOe),
	.statusReg(statusReg), .statusWritten(statusWritten), .statusRejected(statusRejected),
	.selected(selected), .paused(paused), .protAddr(protAddr), .sectorIdx(sectorIdx),
	.blockIdx(blockIdx));

// ===== verification/sfs_master_model.sv
// Behavioural bus master that clocks the front end's serial pins.
`timescale 1ns/1ps

module sfs_master_model (
	input  wire logic       mclk,
	input  wire logic [1:0] pins,
	output logic            sclk,
	output logic            csN,
	output logic            holdN,
	output logic [1:0]      mDrv
);
	logic       mode3;
	logic [1:0] drvEn;
	logic [1:0] drvVal;

	initial begin
		{sclk, csN, holdN, mode3, drvEn, drvVal, mDrv} = 10'h180;
	end

	// A released line toggles every cycle so a stale level never passes for data.
	always @(posedge mclk) begin
		mDrv <= (drvEn & drvVal) | (~drvEn & ~mDrv);
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic start(input logic m3);
		mode3 = m3;
		tick(1);
		sclk <= m3;
		tick(4);
		csN <= 1'b0;
		tick(4);
	endtask

	task automatic finish();
		tick(1);
		sclk  <= mode3;
		drvEn <= 2'h0;
		tick(4);
		csN <= 1'b1;
		tick(8);
	endtask

	task automatic xfer(input logic [7:0] tx, input logic dual, input logic rd,
			input int pAt, input int aAt, output logic [7:0] rx);
		logic [1:0] bits;
		rx = 8'h00;
		for (int k = 0; k < (dual ? 4 : 8); k++) begin
			bits = dual ? tx[7-2*k -: 2] : {1'b0, tx[7-k]};
			tick(1);
			sclk   <= 1'b0;
			drvEn  <= dual ? (rd ? 2'h0 : 2'h3) : 2'h1;
			drvVal <= bits;
			tick(4);
			if (k == pAt) begin
				holdN <= 1'b0;
				tick(8);
				sclk   <= 1'b1;
				drvVal <= ~bits;
				tick(4);
				sclk   <= 1'b0;
				drvVal <= bits;
				tick(4);
				if (k == aAt) csN <= 1'b1;
				tick(8);
				holdN <= 1'b1;
				tick(8);
				if (k == aAt) return;
			end else if (k == aAt) begin
				csN <= 1'b1;
				tick(8);
				return;
			end
			sclk <= 1'b1;
			tick(3);
			@(negedge mclk);
			rx = dual ? {rx[5:0], pins} : {rx[6:0], pins[1]};
		end
	endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the serial flash front end.
`timescale 1ns/1ps

module testbench;
	logic        mclk, rst, wpN, dualMode, txValid, txReady, rxFirst, rxValid, rxReady;
	logic        rxOverrun, statusWritten, statusRejected, selected, paused, protHit;
	logic        sclk, csN, holdN;
	logic [7:0]  txData, rxData, statusReg, rx;
	logic [18:0] protAddr;
	logic [6:0]  sectorIdx;
	logic [2:0]  blockIdx;
	logic [1:0]  mDrv, dualIoOut, dualIoOe, pins;
	int          nErrors, samplesChecked, nWr, nRej, nPause;

	assign pins = (dualIoOe & dualIoOut) | (~dualIoOe & mDrv);

	sfs_front_end i_dut (.mclk, .rst, .sclk, .csN, .holdN, .wpN, .dualIoIn(pins), .dualIoOut,
		.dualIoOe, .dualMode, .txData, .txValid, .txReady, .rxData, .rxFirst, .rxValid,
		.rxReady, .rxOverrun, .statusReg, .statusWritten, .statusRejected, .selected,
		.paused, .protAddr, .protHit, .sectorIdx, .blockIdx);
	sfs_master_model i_master (.mclk, .pins, .sclk, .csN, .holdN, .mDrv);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (statusWritten === 1'b1) nWr++;
		if (statusRejected === 1'b1) nRej++;
		if (paused === 1'b1) nPause++;
	end

	////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			nErrors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic frame(input logic [23:0] b, input int nb, input logic m3,
			input logic dual, input logic rd, input int pAt, input int aAt);
		i_master.start(m3);
		for (int j = 0; j < nb; j++) begin
			i_master.xfer(b[23-8*j -: 8], dual, rd && j == nb - 1,
				j == nb - 1 ? pAt : -1, j == nb - 1 ? aAt : -1, rx);
		end
		i_master.finish();
	endtask

	// Pops every queued word; checks the first flag and low seven bits of the first, and the whole second only if n > 1; n < 0 skips the count.
	task automatic drain(input logic [7:0] e0, input logic [7:0] e1, input int n);
		int got;
		got = 0;
		repeat (40) begin
			@(negedge mclk);
			if (rxValid === 1'b1) begin
				if (got == 0) check({rxFirst, rxData[6:0]}, {1'b1, e0[6:0]});
				if (got == 1 && n > 1) check(rxData, e1);
				got++;
				@(posedge mclk) rxReady <= 1'b1;
				@(posedge mclk) rxReady <= 1'b0;
			end
		end
		if (n >= 0) check(8'(got), 8'(n));
	endtask

	task automatic push_tx(input logic [7:0] d);
		int t;
		t = 0;
		@(posedge mclk);
		txData  <= d;
		txValid <= 1'b1;
		// Ready is looked at between edges, so the edge that takes the word is not raced.
		do begin
			@(negedge mclk);
			t++;
		end while (txReady !== 1'b1 && t < 50);
		@(posedge mclk);
		txValid <= 1'b0;
		if (t >= 50) begin
			nErrors++;
			results();
		end
		@(negedge mclk);
		check({7'h0, txReady}, 8'h00);
	endtask

	////////////////////////////////////////
	task automatic t_fill();
		frame(24'h01ff5a, 3, 0, 0, 0, -1, -1);
		check(statusReg, 8'hbc);
		check(8'(nWr), 8'h01);
		check({7'h0, rxOverrun}, 8'h01);
		drain(8'h01, 8'hff, 2);
	endtask

	task automatic t_locked();
		@(posedge mclk) wpN <= 1'b0;
		frame(24'h010000, 2, 0, 0, 0, -1, -1);
		check(statusReg, 8'hbc);
		check({4'(nRej), 4'(nWr)}, 8'h11);
		check({7'h0, rxOverrun}, 8'h00);
		drain(8'h01, 8'h00, 2);
	endtask

	task automatic t_pause();
		@(posedge mclk) wpN <= 1'b1;
		frame(24'h012c00, 2, 1, 0, 0, 3, -1);
		check(statusReg, 8'h2c);
		check(8'(nPause > 0), 8'h01);
		drain(8'h01, 8'h2c, 2);
	endtask

	task automatic t_prot();
		for (int j = 0; j < 8; j++) begin
			@(posedge mclk) protAddr <= {3'(j), 16'hffff};
			repeat (2) @(posedge mclk);
			@(negedge mclk);
			check({sectorIdx, protHit}, {3'(j), 4'hf, j < 4});
			check({5'h0, blockIdx}, 8'(j));
		end
	endtask

	task automatic t_abort();
		frame(24'h015500, 2, 0, 0, 0, 2, 2);
		check({selected, paused, statusReg[5:0]}, 8'h2c);
		drain(8'h01, 8'h00, 1);
		frame(24'h010000, 1, 0, 0, 0, -1, 5);
		drain(8'h00, 8'h00, 0);
		@(posedge mclk) wpN <= 1'b0;
		frame(24'h01a400, 2, 0, 0, 0, -1, -1);
		check({statusReg, 8'(nWr)}, 16'ha403);
		drain(8'h01, 8'ha4, 2);
	endtask

	task automatic t_read();
		push_tx(8'ha5);
		frame(24'h0b0000, 2, 0, 0, 1, -1, -1);
		check(rx, 8'ha5);
		drain(8'h0b, 8'h00, 2);
		@(posedge mclk) dualMode <= 1'b1;
		push_tx(8'h3c);
		frame(24'h3b0000, 2, 1, 1, 1, -1, -1);
		check(rx, 8'h3c);
		drain(8'h3b, 8'h00, -1);
		@(posedge mclk) dualMode <= 1'b0;
	endtask

	initial begin
		{rst, wpN, dualMode, txValid, rxReady} = 5'h18;
		txData   = 8'h00;
		protAddr = 19'h0;
		{nErrors, samplesChecked, nWr, nRej, nPause} = '0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		t_fill();
		t_locked();
		t_pause();
		t_prot();
		t_abort();
		t_read();
		results();
	end
endmodule
